// ### hdl/rdc_pkg.sv
`default_nettype none
package rdc_pkg;
   // Word index of each register; the byte address is four times the index
   localparam logic [11:0] RDC_CTRL_IDX    = 12'hf2e;
   localparam logic [11:0] RDC_LEVEL_IDX   = 12'hf2f;
   localparam logic [13:0] RDC_CTRL_ADDR   = {RDC_CTRL_IDX, 2'b00};
   localparam logic [13:0] RDC_LEVEL_ADDR  = {RDC_LEVEL_IDX, 2'b00};
   localparam int          RDC_ADDR_W      = 14;
   // Control register field positions
   localparam int          RDC_EN_BIT      = 7;
   localparam int          RDC_OEA_BIT     = 5;
   localparam int          RDC_OEB_BIT     = 4;
   localparam int          RDC_PSS_HI      = 3;
   localparam int          RDC_PSS_LO      = 2;
   localparam int          RDC_NSS_BIT     = 0;
   localparam int          RDC_LEVEL_W     = 5;
   localparam logic [7:0]  RDC_CTRL_MASK   = 8'hbd;
   localparam logic [7:0]  RDC_LEVEL_MASK  = 8'h1f;
   localparam logic [7:0]  RDC_CTRL_RST    = 8'h00;
   localparam logic [4:0]  RDC_LEVEL_RST   = 5'h00;
   // Positive source encodings
   localparam logic [1:0]  RDC_PSS_AVDD    = 2'h0;
   localparam logic [1:0]  RDC_PSS_VREFP   = 2'h1;
   localparam logic [1:0]  RDC_PSS_FIXED   = 2'h2;
   localparam logic [1:0]  RDC_PSS_RSVD    = 2'h3;
   // Count loaded into wait_cnt on a read; the read waits one cycle more than this
   localparam logic [1:0]  RDC_RD_WAIT     = 2'h1;
   typedef enum logic [1:0] {
      RDC_ST_IDLE = 2'b01,
      RDC_ST_WAIT = 2'b10
   } rdc_bus_e;
endpackage : rdc_pkg
`default_nettype wire

// ### hdl/rdc_pin_mux.sv
`default_nettype none
module rdc_pin_mux
   import rdc_pkg::*;
(
   input  wire logic i_analog_sel,
   input  wire logic i_dig_out,
   input  wire logic i_dig_oe,
   input  wire logic i_pullup_en,
   input  wire logic i_pad_in,
   output logic      o_pad_out,
   output logic      o_pad_oe,
   output logic      o_pullup_on,
   output logic      o_input_buf_en,
   output logic      o_dig_in,
   output logic      o_analog_connect
);
   // Analog takeover removes every digital function of the pin
   assign o_analog_connect = i_analog_sel;
   assign o_pad_oe         = i_dig_oe & ~i_analog_sel;
   assign o_pad_out        = i_dig_out & ~i_analog_sel;
   assign o_pullup_on      = i_pullup_en & ~i_analog_sel;
   assign o_input_buf_en   = ~i_analog_sel;
   // Reads as zero so a floating analog level cannot leak into software
   assign o_dig_in         = i_pad_in & ~i_analog_sel;
endmodule : rdc_pin_mux
`default_nettype wire

// ### hdl/rdc_top.sv
`default_nettype none
module rdc_top
   import rdc_pkg::*;
#(
   parameter int LEVEL_W = RDC_LEVEL_W
)
(
   input  wire logic                  i_sys_clk,
   input  wire logic                  i_sys_rst,
   input  wire logic [RDC_ADDR_W-1:0] i_avs_address,
   input  wire logic                  i_avs_read,
   input  wire logic                  i_avs_write,
   input  wire logic [31:0]           i_avs_writedata,
   input  wire logic [3:0]            i_avs_byteenable,
   output logic      [31:0]           o_avs_readdata,
   output logic      [1:0]            o_avs_response,
   output logic                       o_avs_waitrequest,
   input  wire logic                  i_wake_event,
   input  wire logic [1:0]            i_pin_dig_out,
   input  wire logic [1:0]            i_pin_dig_oe,
   input  wire logic [1:0]            i_pin_pullup_en,
   input  wire logic [1:0]            i_pin_pad_in,
   output logic      [1:0]            o_pin_pad_out,
   output logic      [1:0]            o_pin_pad_oe,
   output logic      [1:0]            o_pin_pullup_on,
   output logic      [1:0]            o_pin_input_buf_en,
   output logic      [1:0]            o_pin_dig_in,
   output logic                       o_ladder_enable,
   output logic      [LEVEL_W-1:0]    o_level_code,
   output logic      [1:0]            o_positive_source_select,
   output logic                       o_positive_source_reserved,
   output logic                       o_negative_source_select,
   output logic      [LEVEL_W:0]      o_ladder_step,
   output logic                       o_route_comparator,
   output logic                       o_route_converter,
   output logic                       o_analog_out_pin_a,
   output logic                       o_analog_out_pin_b
);
   typedef struct packed {
      rdc_bus_e           bus;
      logic [1:0]         wait_cnt;
      logic [7:0]         ctrl;
      logic [LEVEL_W-1:0] level;
      logic [31:0]        rdata;
      logic [1:0]         resp;
   } rdc_state_s;

   rdc_state_s state_reg;
   rdc_state_s state_next;

   function automatic logic hit_ctrl(input logic [RDC_ADDR_W-1:0] a);
      hit_ctrl = (a == RDC_CTRL_ADDR);
   endfunction : hit_ctrl

   function automatic logic hit_level(input logic [RDC_ADDR_W-1:0] a);
      hit_level = (a == RDC_LEVEL_ADDR);
   endfunction : hit_level

   logic       wr_ok;
   logic [7:0] level_rd;

   assign level_rd = 8'(state_reg.level) & RDC_LEVEL_MASK;
   // Writes finish without wait; only reads take two wait cycles to build data
   assign wr_ok    = i_avs_write & (state_reg.bus == RDC_ST_IDLE);

   always_comb begin
      state_next = state_reg;
      unique case (state_reg.bus)
         RDC_ST_IDLE: begin
            if (i_avs_write && i_avs_byteenable[0]) begin
               if (hit_ctrl(i_avs_address)) begin
                  state_next.ctrl = i_avs_writedata[7:0] & RDC_CTRL_MASK;
               end else if (hit_level(i_avs_address)) begin
                  state_next.level = i_avs_writedata[LEVEL_W-1:0];
               end
            end
            if (i_avs_write) begin
               state_next.resp = (hit_ctrl(i_avs_address) || hit_level(i_avs_address))
                                 ? 2'h0 : 2'h2;
            end
            if (i_avs_read) begin
               state_next.bus      = RDC_ST_WAIT;
               state_next.wait_cnt = RDC_RD_WAIT;
               state_next.resp     = 2'h0;
               if (hit_ctrl(i_avs_address)) begin
                  state_next.rdata = {24'h000000, state_reg.ctrl & RDC_CTRL_MASK};
               end else if (hit_level(i_avs_address)) begin
                  state_next.rdata = {24'h000000, level_rd};
               end else begin
                  state_next.rdata = 32'h00000000;
                  state_next.resp  = 2'h2;
               end
            end
         end
         RDC_ST_WAIT: begin
            if (state_reg.wait_cnt != 2'h0) begin
               state_next.wait_cnt = state_reg.wait_cnt - 2'h1;
            end else begin
               state_next.bus = RDC_ST_IDLE;
            end
         end
      endcase
      // Wake events touch nothing; the register simply keeps its value
      if (i_wake_event) begin
         state_next.ctrl = state_next.ctrl;
      end
      if (i_sys_rst) begin
         state_next.bus      = RDC_ST_IDLE;
         state_next.wait_cnt = 2'h0;
         state_next.ctrl     = RDC_CTRL_RST;
         state_next.level    = RDC_LEVEL_RST;
         state_next.rdata    = 32'h00000000;
         state_next.resp     = 2'h0;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      state_reg <= state_next;
   end

   // Read waits until the read data register is loaded and aged
   assign o_avs_waitrequest = i_avs_read &
                              !(state_reg.bus == RDC_ST_WAIT && state_reg.wait_cnt == 2'h0);
   assign o_avs_readdata    = state_reg.rdata;
   assign o_avs_response    = state_reg.resp;

   assign o_ladder_enable            = state_reg.ctrl[RDC_EN_BIT];
   assign o_level_code               = state_reg.level;
   assign o_positive_source_select   = state_reg.ctrl[RDC_PSS_HI:RDC_PSS_LO];
   assign o_positive_source_reserved = (o_positive_source_select == RDC_PSS_RSVD);
   assign o_negative_source_select   = state_reg.ctrl[RDC_NSS_BIT];
   // Ladder tap: fraction level/2^5 of the span above the negative source
   assign o_ladder_step      = o_ladder_enable ? {1'b0, state_reg.level} : '0;
   assign o_route_comparator = o_ladder_enable;
   assign o_route_converter  = o_ladder_enable;

   logic [1:0] pin_sel;
   logic [1:0] pin_conn;
   assign pin_sel = {state_reg.ctrl[RDC_OEB_BIT], state_reg.ctrl[RDC_OEA_BIT]};

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_pin
         rdc_pin_mux u_mux (
            .i_analog_sel     (pin_sel[g]),
            .i_dig_out        (i_pin_dig_out[g]),
            .i_dig_oe         (i_pin_dig_oe[g]),
            .i_pullup_en      (i_pin_pullup_en[g]),
            .i_pad_in         (i_pin_pad_in[g]),
            .o_pad_out        (o_pin_pad_out[g]),
            .o_pad_oe         (o_pin_pad_oe[g]),
            .o_pullup_on      (o_pin_pullup_on[g]),
            .o_input_buf_en   (o_pin_input_buf_en[g]),
            .o_dig_in         (o_pin_dig_in[g]),
            .o_analog_connect (pin_conn[g])
         );
      end
   endgenerate

   assign o_analog_out_pin_a = pin_conn[0];
   assign o_analog_out_pin_b = pin_conn[1];

   // Assertions
   a_enable_follows: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      !(wr_ok && i_avs_byteenable[0] && hit_ctrl(i_avs_address))
      |=> $stable(o_ladder_enable))
      else $error("enable changed without write");
   a_ctrl_write: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      (wr_ok && i_avs_byteenable[0] && i_avs_address == 14'h3cb8)
      |=> o_ladder_enable == $past(i_avs_writedata[7])) else $error("ctrl write lost");
   a_level_write: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      (wr_ok && i_avs_byteenable[0] && i_avs_address == 14'h3cbc)
      |=> o_level_code == $past(i_avs_writedata[4:0])) else $error("level write lost");
   a_step_value: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      o_ladder_step == (o_ladder_enable ? {1'b0, o_level_code} : 6'h00))
      else $error("ladder step wrong");
   a_pin_analog: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      o_analog_out_pin_a |-> !o_pin_pad_oe[0] && !o_pin_pullup_on[0] && !o_pin_input_buf_en[0])
      else $error("pin a digital active");
   a_pin_read_zero: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      o_analog_out_pin_b |-> o_pin_dig_in[1] == 1'b0) else $error("pin b read not zero");
   a_wake_keep: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      (i_wake_event && !i_avs_write) |=> $stable(state_reg.ctrl)) else $error("wake changed ctrl");
   a_reset_clear: assert property (@(posedge i_sys_clk)
      i_sys_rst |=> !o_ladder_enable && !o_analog_out_pin_a && !o_analog_out_pin_b
                    && o_level_code == 5'h00) else $error("reset left state");
   a_unimpl_zero: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      state_reg.ctrl[6] == 1'b0 && state_reg.ctrl[1] == 1'b0) else $error("unimpl bit set");
   a_read_answer: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      (i_avs_read && state_reg.bus == RDC_ST_IDLE) |-> o_avs_waitrequest ##1 o_avs_waitrequest
      ##1 !o_avs_waitrequest) else $error("read latency wrong");

   // Control and level registers change only through their own writes
   a_ctrl_hold: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      !(wr_ok && i_avs_byteenable[0] && hit_ctrl(i_avs_address))
      |=> $stable(state_reg.ctrl))
      else $error("control changed without write");

   a_level_hold: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      !(wr_ok && i_avs_byteenable[0] && hit_level(i_avs_address))
      |=> $stable(o_level_code))
      else $error("level changed without write");

   a_ctrl_no_lane: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      (i_avs_write && !i_avs_byteenable[0])
      |=> $stable(state_reg.ctrl) && $stable(state_reg.level))
      else $error("write without lane stored");

   a_unmapped_write: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      (wr_ok && !hit_ctrl(i_avs_address) && !hit_level(i_avs_address))
      |=> $stable(state_reg.ctrl) && $stable(state_reg.level) && o_avs_response == 2'h2)
      else $error("unmapped write stored");

   a_pss_write: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      (wr_ok && i_avs_byteenable[0] && hit_ctrl(i_avs_address))
      |=> o_positive_source_select == $past(i_avs_writedata[RDC_PSS_HI:RDC_PSS_LO]))
      else $error("positive source write lost");

   a_pss_reserved: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      o_positive_source_reserved == (o_positive_source_select == RDC_PSS_RSVD))
      else $error("reserved flag wrong");

   a_nss_write: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      (wr_ok && i_avs_byteenable[0] && hit_ctrl(i_avs_address))
      |=> o_negative_source_select == $past(i_avs_writedata[RDC_NSS_BIT]))
      else $error("negative source write lost");

   a_pin_a_connect: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      (wr_ok && i_avs_byteenable[0] && hit_ctrl(i_avs_address))
      |=> o_analog_out_pin_a == $past(i_avs_writedata[RDC_OEA_BIT]))
      else $error("pin a connect lost");

   a_pin_b_connect: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      (wr_ok && i_avs_byteenable[0] && hit_ctrl(i_avs_address))
      |=> o_analog_out_pin_b == $past(i_avs_writedata[RDC_OEB_BIT]))
      else $error("pin b connect lost");

   a_step_range: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      o_ladder_step[LEVEL_W] == 1'b0)
      else $error("ladder step above top level");

   a_step_off: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      !o_ladder_enable |-> o_ladder_step == '0 && !o_route_comparator)
      else $error("ladder active while off");

   a_route_follow: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      o_route_comparator == o_ladder_enable && o_route_converter == o_ladder_enable)
      else $error("route differs from enable");

   a_wake_level: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      (i_wake_event && !i_avs_write) |=> $stable(o_level_code))
      else $error("wake changed level");

   a_reset_ctrl: assert property (@(posedge i_sys_clk)
      i_sys_rst |=> state_reg.ctrl == RDC_CTRL_RST && o_ladder_step == '0
                    && state_reg.bus == RDC_ST_IDLE && o_avs_response == 2'h0)
      else $error("reset left control set");

   // Pin takeover: a selected pin loses its digital functions; an unselected pin passes the port logic straight through
   a_pin_b_analog: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      o_analog_out_pin_b
      |-> !o_pin_pad_oe[1] && !o_pin_pullup_on[1] && !o_pin_input_buf_en[1]
          && !o_pin_pad_out[1])
      else $error("pin b digital active");

   a_pin_a_zero: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      o_analog_out_pin_a
      |-> o_pin_dig_in[0] == 1'b0 && o_pin_pad_out[0] == 1'b0)
      else $error("pin a read not zero");

   a_pin_a_digital: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      !o_analog_out_pin_a
      |-> o_pin_pad_oe[0] == i_pin_dig_oe[0] && o_pin_pad_out[0] == i_pin_dig_out[0]
          && o_pin_pullup_on[0] == i_pin_pullup_en[0] && o_pin_input_buf_en[0]
          && o_pin_dig_in[0] == i_pin_pad_in[0])
      else $error("pin a digital path blocked");

   a_pin_b_digital: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      !o_analog_out_pin_b
      |-> o_pin_pad_oe[1] == i_pin_dig_oe[1] && o_pin_pad_out[1] == i_pin_dig_out[1]
          && o_pin_pullup_on[1] == i_pin_pullup_en[1] && o_pin_input_buf_en[1]
          && o_pin_dig_in[1] == i_pin_pad_in[1])
      else $error("pin b digital path blocked");

   // Bus side: data and response stand until the next access
   a_read_ctrl: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      (i_avs_read && state_reg.bus == RDC_ST_IDLE && hit_ctrl(i_avs_address))
      |=> o_avs_readdata[31:8] == 24'h000000 && o_avs_readdata[6] == 1'b0
          && o_avs_readdata[1] == 1'b0 && o_avs_readdata[7] == $past(o_ladder_enable))
      else $error("control read data wrong");

   a_read_level: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      (i_avs_read && state_reg.bus == RDC_ST_IDLE && hit_level(i_avs_address))
      |=> o_avs_readdata[31:LEVEL_W] == '0 && o_avs_response == 2'h0
          && o_avs_readdata[LEVEL_W-1:0] == $past(o_level_code))
      else $error("level read data wrong");

   a_read_unmapped: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      (i_avs_read && state_reg.bus == RDC_ST_IDLE
       && !hit_ctrl(i_avs_address) && !hit_level(i_avs_address))
      |=> o_avs_readdata == 32'h00000000 && o_avs_response == 2'h2)
      else $error("unmapped read not refused");

   a_read_hold: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      !(i_avs_read && state_reg.bus == RDC_ST_IDLE)
      |=> $stable(o_avs_readdata))
      else $error("read data moved between reads");

   a_resp_hold: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      !((i_avs_read || i_avs_write) && state_reg.bus == RDC_ST_IDLE)
      |=> $stable(o_avs_response))
      else $error("response moved between accesses");

   a_no_read_wait: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      !i_avs_read |-> !o_avs_waitrequest)
      else $error("wait raised without read");

   a_bus_onehot: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      $onehot(state_reg.bus))
      else $error("bus state not one-hot");

   a_wait_idle: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      state_reg.bus == RDC_ST_IDLE |-> state_reg.wait_cnt == 2'h0)
      else $error("wait count left over");

   c_enable_on: cover property (@(posedge i_sys_clk) $rose(o_ladder_enable));
   c_both_pins: cover property (@(posedge i_sys_clk) o_analog_out_pin_a && o_analog_out_pin_b);
   c_full_level: cover property (@(posedge i_sys_clk) o_ladder_step == 6'h1f);
   c_reserved: cover property (@(posedge i_sys_clk) o_positive_source_reserved);
   c_unmapped: cover property (@(posedge i_sys_clk) o_avs_response == 2'h2);
endmodule : rdc_top
`default_nettype wire

// ### tb/ratiometric_dac_control_tb_top.sv
`default_nettype none
module ratiometric_dac_control_tb_top import rdc_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, rst, rd, wr, wake, wait_rq, en, pss_rsv, negative_source_select, r_cmp, r_cnv, pin_a, pin_b;
   logic [13:0] addr;
   logic [31:0] wdata, rdata, got;
   logic [3:0]  be;
   logic [1:0]  resp, gresp, p_out, p_oe, p_pu, p_pad, pad_out, pad_oe, pu_on, ibuf, dig_in, positive_source_select;
   logic [5:0]  step;
   logic [4:0]  lvl;
   int          fail_count, n_tests;
   rdc_top DUT (.i_sys_clk(clk), .i_sys_rst(rst), .i_avs_address(addr), .i_avs_read(rd),
      .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(be),
      .o_avs_readdata(rdata), .o_avs_response(resp), .o_avs_waitrequest(wait_rq),
      .i_wake_event(wake), .i_pin_dig_out(p_out), .i_pin_dig_oe(p_oe), .i_pin_pullup_en(p_pu),
      .i_pin_pad_in(p_pad), .o_pin_pad_out(pad_out), .o_pin_pad_oe(pad_oe),
      .o_pin_pullup_on(pu_on), .o_pin_input_buf_en(ibuf), .o_pin_dig_in(dig_in),
      .o_ladder_enable(en), .o_level_code(lvl), .o_positive_source_select(positive_source_select),
      .o_positive_source_reserved(pss_rsv), .o_negative_source_select(negative_source_select),
      .o_ladder_step(step), .o_route_comparator(r_cmp), .o_route_converter(r_cnv),
      .o_analog_out_pin_a(pin_a), .o_analog_out_pin_b(pin_b));
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   // Request held from one rising edge until the edge that sees waitrequest low
   task automatic bus(input logic w, input logic [13:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= {24'h0, d};
      wr <= w;
      rd <= !w;
      // Read before this edge's own updates land, so it is what the design sampled
      do begin
         @(posedge clk);
      end while (wait_rq !== 1'b0);
      got = rdata;
      gresp = resp;
      wr <= 1'b0;
      rd <= 1'b0;
      @(negedge clk);
   endtask : bus
   task automatic t_reset;
      bus(0, RDC_CTRL_ADDR, 8'h00);
      chk(got, {24'h0, RDC_CTRL_RST});
      chk(32'(gresp), 32'h0);
      bus(0, RDC_LEVEL_ADDR, 8'h00);
      chk(got, 32'h0);
      chk(32'({en, pin_a, pin_b, lvl}), 32'h0);
      $display("test reset done");
   endtask : t_reset
   task automatic t_ctrl;
      bus(1, RDC_CTRL_ADDR, 8'hff);
      bus(0, RDC_CTRL_ADDR, 8'h00);
      chk(got, {24'h0, RDC_CTRL_MASK});
      chk(32'({en, r_cmp, r_cnv, pin_a, pin_b, pss_rsv, negative_source_select}), 32'h7f);
      for (int p = 0; p < 4; p++) begin
         bus(1, RDC_CTRL_ADDR, {4'h8, p[1:0], 1'b0, p[0]});
         chk(32'({positive_source_select, pss_rsv, negative_source_select, en}), 32'({p[1:0], p == 3, p[0], 1'b1}));
      end
      bus(1, RDC_CTRL_ADDR, 8'h0c);
      chk(32'({en, r_cmp, r_cnv, positive_source_select}), 32'h3);
      $display("test control done");
   endtask : t_ctrl
   task automatic t_level;
      logic [4:0] codes [4] = '{5'h00, 5'h01, 5'h15, 5'h1f};
      bus(1, RDC_CTRL_ADDR, 8'h80);
      for (int i = 0; i < 4; i++) begin
         bus(1, RDC_LEVEL_ADDR, {3'b111, codes[i]});
         bus(0, RDC_LEVEL_ADDR, 8'h00);
         chk(got, {27'h0, codes[i]});
         chk(32'(step), 32'(codes[i]));
      end
      bus(1, RDC_CTRL_ADDR, 8'h00);
      chk(32'({step, lvl}), 32'h1f);
      $display("test level done");
   endtask : t_level
   task automatic t_pins;
      @(posedge clk);
      p_out <= 2'b11;
      p_oe <= 2'b11;
      p_pu <= 2'b11;
      p_pad <= 2'b11;
      bus(1, RDC_CTRL_ADDR, 8'h20);
      chk(32'({pad_out, pad_oe, pu_on, dig_in, ibuf[0]}), 32'h154);
      bus(1, RDC_CTRL_ADDR, 8'h10);
      chk(32'({pad_out, pad_oe, pu_on, dig_in, ibuf[1]}), 32'h0aa);
      chk(32'({pin_a, pin_b, en}), 32'h2);
      $display("test pins done");
   endtask : t_pins
   task automatic t_wake_bus;
      bus(1, RDC_CTRL_ADDR, 8'hb5);
      @(posedge clk);
      wake <= 1'b1;
      @(posedge clk);
      wake <= 1'b0;
      bus(0, RDC_CTRL_ADDR, 8'h00);
      chk(got, 32'hb5);
      bus(1, RDC_CTRL_ADDR, 8'h35);
      bus(1, 14'h3cc0, 8'hff);
      bus(0, 14'h3cc0, 8'h00);
      chk({got[29:0], gresp}, 32'h2);
      @(posedge clk);
      be <= 4'h0;
      bus(1, RDC_CTRL_ADDR, 8'hff);
      @(posedge clk);
      be <= 4'h1;
      bus(0, RDC_CTRL_ADDR, 8'h00);
      chk(got, 32'h35);
      $display("test wake and bus done");
   endtask : t_wake_bus
   task automatic t_rst_mid;
      bus(1, RDC_CTRL_ADDR, 8'hbd);
      bus(1, RDC_LEVEL_ADDR, 8'h1f);
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      bus(0, RDC_LEVEL_ADDR, 8'h00);
      chk(32'({got[7:0], en, pin_a, pin_b, lvl, step}), 32'h0);
      $display("test mid reset done");
   endtask : t_rst_mid
   task automatic give_verdict;
      $display("comparisons=%0d mismatches=%0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : give_verdict
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // Whole run is about 100 cycles; the 5000-cycle limit leaves a wide margin
   initial begin
      #200000;
      fail_count++;
      give_verdict();
   end
   initial begin
      {rd, wr, wake, addr, wdata, p_out, p_oe, p_pu, p_pad} = '0;
      be = 4'h1;
      rst = 1'b1;
      fail_count = 0;
      n_tests = 0;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_ctrl();
      t_level();
      t_pins();
      t_wake_bus();
      t_rst_mid();
      give_verdict();
   end
endmodule : ratiometric_dac_control_tb_top
`default_nettype wire
